//--- shared/ctl_chan_pkg.sv
/*
 * Constants for the control channel error check block: register indexes,
 * field positions, reset values, injected error codes and bus states.
 * Assumes a 32-bit AHB-Lite register bus with one register per word.
 */
package ctl_chan_pkg;
    // ****************************************
    // register indexes (byte address is index times four)
    // ****************************************
    localparam logic [7:0] IDX_STATUS     = 8'h6d;
    localparam logic [7:0] IDX_CONFIG     = 8'h6e;
    localparam logic [7:0] IDX_FAULT      = 8'h6f;
    localparam logic [7:0] IDX_REMOTE_ONE = 8'h70;
    localparam logic [7:0] IDX_REMOTE_TWO = 8'h71;
    localparam logic [7:0] IDX_ALIAS_ONE  = 8'h77;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h78;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h79;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int unsigned CFG_ENH_BIT     = 0;
    localparam int unsigned CFG_CHK_BIT     = 1;
    localparam int unsigned CFG_EARLY_BIT   = 2;
    localparam int unsigned CFG_TERM_BIT    = 4;
    localparam logic [7:0]  CFG_RESET       = 8'h20;
    localparam logic [7:0]  CFG_WMASK       = 8'h3f;
    localparam int unsigned FAULT_FORCE_BIT = 6;
    localparam logic [5:0]  FAULT_RESET     = 6'h00;
    localparam logic [6:0]  ADDR_RESET      = 7'h00;
    localparam int unsigned STATUS_RESP_BIT = 0;
    localparam int unsigned IRQ_W           = 4;
    localparam int unsigned IRQ_MISMATCH    = 0;
    localparam int unsigned IRQ_CRC         = 1;
    localparam int unsigned IRQ_ABORT       = 2;
    localparam int unsigned IRQ_INJECT      = 3;
    localparam int unsigned SEQ_W_DEF       = 4;
    localparam int unsigned NUM_FRAMES      = 8;
    // ****************************************
    // injected error codes
    // ****************************************
    localparam logic [2:0] ERR_NONE      = 3'h0;
    localparam logic [2:0] ERR_CRC       = 3'h1;
    localparam logic [2:0] ERR_SEQ       = 3'h2;
    localparam logic [2:0] ERR_DROP      = 3'h3;
    localparam logic [2:0] ERR_DATA_RAND = 3'h4;
    localparam logic [2:0] ERR_DATA_BIT0 = 3'h5;
    localparam logic [2:0] LFSR_SEED     = 3'h1;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} bus_state_e;
endpackage

//--- shared/inject_if.sv
/*
 * Carrier between the register/response logic and the frame injector.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface inject_if #(parameter int unsigned SEQ_W = 4);
    logic             arm;
    logic [2:0]       err_type;
    logic [2:0]       frame_idx;
    logic             in_valid;
    logic             in_ready;
    logic             in_first;
    logic [7:0]       in_data;
    logic             out_valid;
    logic             out_ready;
    logic             out_first;
    logic             out_crc_bad;
    logic [7:0]       out_data;
    logic [SEQ_W-1:0] out_seq;
    logic             done;
    logic             armed;

    modport ctrl (output arm, err_type, frame_idx, in_valid, in_first, in_data, out_ready,
                  input in_ready, out_valid, out_first, out_crc_bad, out_data, out_seq, done, armed);
    modport inj  (input arm, err_type, frame_idx, in_valid, in_first, in_data, out_ready,
                  output in_ready, out_valid, out_first, out_crc_bad, out_data, out_seq, done, armed);
endinterface
`default_nettype wire

//--- design/frame_injector.sv
/*
 * Forward frame stage: numbers each control byte and, once per arming,
 * corrupts the selected byte of a transfer in the selected way.
 * Assumes the controller pulses arm for one cycle per request.
 */
`timescale 1ns/10ps
`default_nettype none
module frame_injector #(
    parameter int unsigned SEQ_W = 4
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // injection channel
    inject_if.inj     link
);
    import ctl_chan_pkg::*;

    generate
        if (SEQ_W < 2) begin : g_bad_seq
            $error("SEQ_W must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic             armed;
        logic [3:0]       cnt;
        logic [SEQ_W-1:0] seq;
        logic [2:0]       lfsr;
        logic             ov;
        logic             ofirst;
        logic             ocrc;
        logic [7:0]       odata;
        logic [SEQ_W-1:0] oseq;
        logic             done;
    } inj_state_s;

    inj_state_s st;
    inj_state_s nxt;
    logic       acc;
    logic [3:0] idx;
    logic       hit;

    // ****************************************
    // frame selection
    // ****************************************
    assign link.in_ready = !st.ov || link.out_ready;
    assign acc = link.in_valid && link.in_ready;
    assign idx = link.in_first ? 4'h0 : st.cnt;
    assign hit = acc && st.armed && (idx == {1'b0, link.frame_idx});

    always_comb begin
        nxt = st;
        nxt.done = hit;
        nxt.lfsr = {st.lfsr[1:0], st.lfsr[2] ^ st.lfsr[1]};
        if (link.arm) begin
            nxt.armed = 1'b1;
        end else if (hit) begin
            nxt.armed = 1'b0;
        end
        if (acc) begin
            nxt.cnt = (idx >= 4'(NUM_FRAMES)) ? 4'(NUM_FRAMES) : idx + 4'h1;
            nxt.seq = st.seq + SEQ_W'(1);
            nxt.ov = 1'b1;
            nxt.ofirst = link.in_first;
            nxt.ocrc = 1'b0;
            nxt.odata = link.in_data;
            nxt.oseq = st.seq;
            if (hit) begin
                case (link.err_type)
                    ERR_CRC: nxt.ocrc = 1'b1;
                    ERR_SEQ: begin
                        nxt.oseq = st.seq + SEQ_W'(1);
                        nxt.seq = st.seq + SEQ_W'(2);
                    end
                    ERR_DROP: nxt.ov = 1'b0;
                    ERR_DATA_RAND: nxt.odata = link.in_data ^ (8'h01 << st.lfsr);
                    ERR_DATA_BIT0: nxt.odata = link.in_data ^ 8'h01;
                    default: nxt.ocrc = 1'b0;
                endcase
            end
        end else if (link.out_ready) begin
            nxt.ov = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
            st.lfsr <= LFSR_SEED;
        end else begin
            st <= nxt;
        end
    end

    assign link.out_valid = st.ov;
    assign link.out_first = st.ofirst;
    assign link.out_crc_bad = st.ocrc;
    assign link.out_data = st.odata;
    assign link.out_seq = st.oseq;
    assign link.done = st.done;
    assign link.armed = st.armed;

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_single_shot: assert property (hit && !link.arm |=> !link.armed ##1 !link.done)
        else $error("injection stayed armed after its frame");
    a_crc_inject: assert property (hit && link.err_type == ERR_CRC |=> link.out_valid && link.out_crc_bad)
        else $error("crc fault not applied");
    a_none_clean: assert property (hit && link.err_type == ERR_NONE
                                   |=> link.out_data == $past(link.in_data) && !link.out_crc_bad)
        else $error("no-error code altered the frame");
    a_first_frame: assert property (acc && st.armed && link.in_first && link.frame_idx == 3'h0 |=> link.done)
        else $error("frame zero not selected");
    c_drop: cover property (hit && link.err_type == ERR_DROP);
endmodule
`default_nettype wire

//--- design/ctl_chan_check.sv
/*
 * Control channel error check: AHB-Lite registers, returned-data check,
 * early remote read acknowledge, target address remap, abort on errors
 * and forward frame fault injection through frame_injector.
 * Assumes the local I2C side presents bytes with a first-byte mark and the
 * remote side returns one response per forwarded byte.
 */
`timescale 1ns/10ps
`default_nettype none
module ctl_chan_check #(
    parameter int unsigned SEQ_W = ctl_chan_pkg::SEQ_W_DEF
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // local i2c byte stream
    input  wire logic             loc_valid,
    output logic                  loc_ready,
    input  wire logic             loc_first,
    input  wire logic [7:0]       loc_data,
    output logic                  loc_ack_valid,
    output logic                  loc_ack,
    // forward frames
    output logic                  fwd_valid,
    input  wire logic             fwd_ready,
    output logic                  fwd_first,
    output logic [7:0]            fwd_data,
    output logic [SEQ_W-1:0]      fwd_seq,
    output logic                  fwd_crc_bad,
    // back channel responses
    input  wire logic             bk_valid,
    input  wire logic             bk_ack,
    input  wire logic [7:0]       bk_data,
    input  wire logic             bk_crc_err,
    // status
    output logic                  link_abort,
    output logic                  irq
);
    import ctl_chan_pkg::*;

    typedef struct packed {
        bus_state_e   bus;
        logic [7:0]   idx;
        logic         mapped;
        logic [31:0]  rdata;
        logic [7:0]   cfg;
        logic [5:0]   fault;
        logic [6:0]   remote_one;
        logic [6:0]   remote_two;
        logic [6:0]   alias_one;
        logic         resp_flag;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic         cmp_pending;
        logic [7:0]   cmp_data;
        logic         swallow;
        logic         ack_valid;
        logic         ack;
        logic         abort;
        logic         arm;
    } state_s;

    state_s           st;
    state_s           nxt;
    logic             acc_addr;
    logic             wr_now;
    logic             loc_acc;
    logic             remap_hit;
    logic             read_start;
    logic             mismatch;
    logic             crc_abort;
    logic             mis_abort;
    logic             enh;
    logic             chk_en;
    logic             early_en;
    logic [7:0]       fwd_byte;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;

    inject_if #(.SEQ_W(SEQ_W)) link_if ();

    frame_injector #(.SEQ_W(SEQ_W)) u_inj (
        .clock (clock),
        .rst_n (rst_n),
        .link  (link_if)
    );

    // ****************************************
    // register read mux
    // ****************************************
    function automatic logic [7:0] read_reg(input state_s s);
        logic [7:0] v;
        v = 8'h00;
        if (!s.mapped) begin
            v = 8'h00;
        end else if (s.idx == IDX_STATUS) begin
            v = {7'h00, s.resp_flag};
        end else if (s.idx == IDX_CONFIG) begin
            v = s.cfg;
        end else if (s.idx == IDX_FAULT) begin
            v = {2'h0, s.fault};
        end else if (s.idx == IDX_REMOTE_ONE) begin
            v = {s.remote_one, 1'b0};
        end else if (s.idx == IDX_REMOTE_TWO) begin
            v = {s.remote_two, 1'b0};
        end else if (s.idx == IDX_ALIAS_ONE) begin
            v = {s.alias_one, 1'b0};
        end else if (s.idx == IDX_IRQ_STATUS) begin
            v = {4'h0, s.irq_st};
        end else if (s.idx == IDX_IRQ_MASK) begin
            v = {4'h0, s.irq_mask};
        end
        return v;
    endfunction

    // ****************************************
    // link side decode
    // ****************************************
    assign enh = st.cfg[CFG_ENH_BIT];
    assign chk_en = st.cfg[CFG_CHK_BIT];
    assign early_en = st.cfg[CFG_EARLY_BIT];
    assign acc_addr = hsel && hready && htrans[1];
    assign wr_now = (st.bus == BUS_WRITE) && st.mapped;
    assign loc_acc = loc_valid && link_if.in_ready;
    assign remap_hit = loc_first && (loc_data[7:1] == st.alias_one);
    assign fwd_byte = remap_hit ? {st.remote_one, loc_data[0]} : loc_data;
    assign read_start = loc_acc && loc_first && loc_data[0];
    assign mismatch = bk_valid && !bk_crc_err && st.cmp_pending && (bk_data != st.cmp_data);
    assign crc_abort = bk_valid && bk_crc_err && enh && st.cfg[CFG_TERM_BIT];
    assign mis_abort = mismatch && enh;
    assign w1c = (wr_now && st.idx == IDX_IRQ_STATUS) ? hwdata[IRQ_W-1:0] : '0;
    assign ev = {link_if.done, crc_abort || mis_abort, bk_valid && bk_crc_err, mismatch};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt = st;
        nxt.arm = 1'b0;
        nxt.ack_valid = 1'b0;
        nxt.abort = 1'b0;
        if (wr_now) begin
            if (st.idx == IDX_CONFIG) begin
                nxt.cfg = hwdata[7:0] & CFG_WMASK;
            end else if (st.idx == IDX_FAULT) begin
                nxt.fault = hwdata[5:0];
                nxt.arm = hwdata[FAULT_FORCE_BIT];
            end else if (st.idx == IDX_REMOTE_ONE) begin
                nxt.remote_one = hwdata[7:1];
            end else if (st.idx == IDX_REMOTE_TWO) begin
                nxt.remote_two = hwdata[7:1];
            end else if (st.idx == IDX_ALIAS_ONE) begin
                nxt.alias_one = hwdata[7:1];
            end else if (st.idx == IDX_IRQ_MASK) begin
                nxt.irq_mask = hwdata[IRQ_W-1:0];
            end
        end
        if (st.bus == BUS_READ_WAIT) begin
            nxt.rdata = {24'h000000, read_reg(st)};
            if (st.mapped && st.idx == IDX_STATUS) begin
                nxt.resp_flag = 1'b0;
            end
            nxt.bus = BUS_READ_DONE;
        end else if (acc_addr) begin
            nxt.idx = haddr[9:2];
            nxt.mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
            nxt.bus = hwrite ? BUS_WRITE : BUS_READ_WAIT;
        end else begin
            nxt.bus = BUS_IDLE;
        end
        // set wins over read and write-one clears
        if (mismatch) begin
            nxt.resp_flag = 1'b1;
        end
        nxt.irq_st = (st.irq_st & ~w1c) | ev;
        if (bk_valid) begin
            nxt.cmp_pending = 1'b0;
            if (!bk_crc_err) begin
                if (st.swallow) begin
                    nxt.swallow = 1'b0;
                end else begin
                    nxt.ack_valid = 1'b1;
                    nxt.ack = bk_ack && !(chk_en && mismatch);
                end
            end
        end
        if (crc_abort || mis_abort) begin
            nxt.abort = 1'b1;
            nxt.cmp_pending = 1'b0;
            nxt.swallow = 1'b0;
        end
        if (loc_acc) begin
            nxt.cmp_data = fwd_byte;
            nxt.cmp_pending = 1'b1;
            if (read_start && early_en) begin
                nxt.ack_valid = 1'b1;
                nxt.ack = 1'b1;
                nxt.swallow = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
            st.bus <= BUS_IDLE;
            st.cfg <= CFG_RESET;
            st.fault <= FAULT_RESET;
            st.remote_one <= ADDR_RESET;
            st.remote_two <= ADDR_RESET;
            st.alias_one <= ADDR_RESET;
        end else begin
            st <= nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hreadyout = (st.bus != BUS_READ_WAIT);
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign link_if.arm = st.arm;
    assign link_if.err_type = st.fault[5:3];
    assign link_if.frame_idx = st.fault[2:0];
    assign link_if.in_valid = loc_valid;
    assign link_if.in_first = loc_first;
    assign link_if.in_data = fwd_byte;
    assign link_if.out_ready = fwd_ready;
    assign loc_ready = link_if.in_ready;
    assign loc_ack_valid = st.ack_valid;
    assign loc_ack = st.ack;
    assign fwd_valid = link_if.out_valid;
    assign fwd_first = link_if.out_first;
    assign fwd_data = link_if.out_data;
    assign fwd_seq = link_if.out_seq;
    assign fwd_crc_bad = link_if.out_crc_bad;
    assign link_abort = st.abort;
    assign irq = |(st.irq_st & st.irq_mask);

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_early_read_ack: assert property (read_start && early_en |=> loc_ack_valid && loc_ack)
        else $error("remote read start not acknowledged early");
    a_data_match_pass: assert property (bk_valid && !bk_crc_err && !st.swallow && !mismatch && !read_start
                                        |=> loc_ack_valid && loc_ack == $past(bk_ack))
        else $error("matching response ack not passed through");
    a_mismatch_nack: assert property (mismatch && chk_en && !st.swallow && !read_start
                                      |=> loc_ack_valid && !loc_ack)
        else $error("mismatch did not turn ack into nack");
    a_enh_off_quiet: assert property (!enh |=> !link_abort)
        else $error("abort with enhanced checking off");
    a_mismatch_abort: assert property (mismatch && enh |=> link_abort)
        else $error("mismatch did not terminate");
    a_crc_abort: assert property (bk_valid && bk_crc_err && st.cfg[CFG_ENH_BIT] && st.cfg[CFG_TERM_BIT]
                                  |=> link_abort ##1 (link_abort == ($past(crc_abort) || $past(mis_abort))))
        else $error("crc error did not abort for one cycle");
    a_resp_flag_set: assert property (mismatch |=> st.resp_flag)
        else $error("response mismatch flag not set");
    a_force_reads_zero: assert property (st.bus == BUS_READ_DONE && st.idx == IDX_FAULT
                                         |-> !hrdata[FAULT_FORCE_BIT])
        else $error("force bit read back as one");
    a_remote_bit0_zero: assert property (st.bus == BUS_READ_DONE && st.idx == IDX_REMOTE_ONE |-> !hrdata[0])
        else $error("reserved address bit read as one");
    a_remap_apply: assert property (loc_acc && remap_hit && !link_if.armed
                                    |=> fwd_valid && fwd_data[7:1] == $past(st.remote_one))
        else $error("alias address not remapped");

    c_early_ack: cover property (read_start && early_en);
    c_mismatch_nack: cover property (mismatch && chk_en);
    c_crc_abort: cover property (crc_abort);
    c_inject_done: cover property (link_if.done);
endmodule
`default_nettype wire

//--- dv/remote_deser_model.sv
/*
 * Remote deserializer model: accepts forward bytes and returns one response each.
 * Assumes the forward handshake of ctl_chan_check and one shared clock.
 */
`timescale 1ns/10ps
`default_nettype none
module remote_deser_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // forward frames
    input  wire logic       fwd_valid,
    input  wire logic [7:0] fwd_data,
    output logic            fwd_ready,
    // back channel
    output logic            bk_valid,
    output logic            bk_ack,
    output logic [7:0]      bk_data,
    output logic            bk_crc_err,
    // faults commanded by the bench
    input  wire logic       slow,
    input  wire logic       bad_data,
    input  wire logic       crc_bad
);
    logic take;
    assign take = fwd_valid && fwd_ready;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fwd_ready  <= 1'b0;
            bk_valid   <= 1'b0;
            bk_ack     <= 1'b0;
            bk_data    <= 8'h00;
            bk_crc_err <= 1'b0;
        end else begin
            fwd_ready  <= slow ? !fwd_ready : 1'b1;
            bk_valid   <= take;
            bk_ack     <= take;
            bk_crc_err <= take && crc_bad;
            // echo the byte; idle line toggles so no stale byte is seen
            bk_data    <= take ? fwd_data ^ {7'h0, bad_data} : ~bk_data;
        end
    end
endmodule
`default_nettype wire

//--- dv/test_control_channel_error_check.sv
/*
 * Self-checking bench for ctl_chan_check: registers over AHB-Lite, remap,
 * returned-data check, early ack, abort, interrupts and fault injection.
 * Assumes remote_deser_model as the far side and one 125 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module test_control_channel_error_check;
    import ctl_chan_pkg::*;
    logic        clock, rst_n, hsel, hwrite, loc_valid, loc_first, slow, bad, crc, last_ack, seen;
    logic        hreadyout, hresp, loc_ready, loc_ack_valid, loc_ack, fwd_valid, fwd_ready, fwd_first;
    logic        fwd_crc_bad, bk_valid, bk_ack, bk_crc_err, link_abort, irq;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [7:0]  loc_data, fwd_data, bk_data;
    logic [3:0]  fwd_seq, prev;
    logic [10:0] frm[$];
    int          fail_count, compares, acks, aborts, cyc, n, k, f;
    ctl_chan_check DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .loc_valid(loc_valid), .loc_ready(loc_ready),
        .loc_first(loc_first), .loc_data(loc_data), .loc_ack_valid(loc_ack_valid), .loc_ack(loc_ack),
        .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd_first(fwd_first), .fwd_data(fwd_data),
        .fwd_seq(fwd_seq), .fwd_crc_bad(fwd_crc_bad), .bk_valid(bk_valid), .bk_ack(bk_ack),
        .bk_data(bk_data), .bk_crc_err(bk_crc_err), .link_abort(link_abort), .irq(irq));
    remote_deser_model far (.clock(clock), .rst_n(rst_n), .fwd_valid(fwd_valid), .fwd_data(fwd_data),
        .fwd_ready(fwd_ready), .bk_valid(bk_valid), .bk_ack(bk_ack), .bk_data(bk_data),
        .bk_crc_err(bk_crc_err), .slow(slow), .bad_data(bad), .crc_bad(crc));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {22'h0, a, 2'h0};
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic send(input logic fst, input logic [7:0] d);
        @(posedge clock);
        loc_valid <= 1'b1;
        loc_first <= fst;
        loc_data  <= d;
        do @(posedge clock); while (loc_ready !== 1'b1);
        loc_valid <= 1'b0;
    endtask
    task automatic wait_acks(input int c);
        for (int i = 0; i < 60 && acks < c; i++) @(posedge clock);
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clock);
        chk(irq, e, "irq");
    endtask
    task print_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // monitor and timeout
    // ****************************************
    always @(posedge clock) begin
        if (loc_ack_valid === 1'b1) begin
            acks++;
            last_ack = loc_ack;
        end
        if (link_abort === 1'b1) aborts++;
        if (fwd_valid === 1'b1 && fwd_ready === 1'b1) begin
            frm.push_back({fwd_first, seen && fwd_seq !== prev + 4'h1, fwd_crc_bad, fwd_data});
            prev = fwd_seq;
            seen = 1'b1;
        end
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        {rst_n, hsel, hwrite, loc_valid, loc_first, slow, bad, crc, seen} = '0;
        {haddr, hwdata, htrans, loc_data} = '0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        bus(0, IDX_CONFIG, 0);
        chk(q, {24'h0, CFG_RESET}, "config reset");
        chk(hresp, 0, "okay response");
        bus(0, IDX_FAULT, 0);
        chk(q, 0, "fault reset");
        bus(0, 8'h72, 0);
        chk(q, 0, "unmapped");
        bus(1, IDX_ALIAS_ONE, 32'ha0);
        bus(1, IDX_REMOTE_ONE, 32'h43);
        bus(0, IDX_REMOTE_ONE, 0);
        chk(q, 32'h42, "target reg");
        bus(1, IDX_REMOTE_TWO, 32'hff);
        bus(0, IDX_REMOTE_TWO, 0);
        chk(q, 32'hfe, "second target reg");
        send(1, 8'ha1);
        send(0, 8'h5a);
        for (int i = 0; i < 60 && frm.size() < 2; i++) @(posedge clock);
        chk(frm[0][7:0], 8'h43, "remapped addr");
        chk(frm[1][7:0], 8'h5a, "plain byte");
        $display("test registers and remap done");
        bad <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            bus(1, IDX_CONFIG, 32'h20 | (i << 1));
            n = acks;
            send(0, 8'h30);
            wait_acks(n + 1);
            chk(last_ack, i == 0, "returned data ack");
        end
        bus(0, IDX_STATUS, 0);
        chk(q, 1, "mismatch flag");
        bus(0, IDX_STATUS, 0);
        chk(q, 0, "flag read clear");
        bad <= 1'b0;
        bus(1, IDX_CONFIG, 32'h24);
        n = acks;
        send(1, 8'h09);
        wait_acks(n + 1);
        chk(last_ack, 1, "early ack");
        repeat (8) @(posedge clock);
        chk(acks, n + 1, "swallowed reply");
        $display("test ack handling done");
        bus(1, IDX_IRQ_MASK, 32'h04);
        crc <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            bus(1, IDX_CONFIG, 32'h30 | i);
            n = aborts;
            send(0, 8'h44);
            repeat (8) @(posedge clock);
            chk(aborts - n, i, "abort");
        end
        crc <= 1'b0;
        bad <= 1'b1;
        n = aborts;
        send(0, 8'h44);
        repeat (8) @(posedge clock);
        chk(aborts - n, 1, "mismatch abort");
        bad <= 1'b0;
        chk_irq(1);
        bus(1, IDX_IRQ_STATUS, 32'h0f);
        chk_irq(0);
        $display("test abort and irq done");
        bus(1, IDX_IRQ_MASK, 0);
        bus(1, IDX_CONFIG, 32'h20);
        slow <= 1'b1;
        for (int t = 0; t < 8; t++) begin
            f = (t * 3 + 4) % 8;
            bus(1, IDX_FAULT, 32'h40 | (t << 3) | f);
            bus(0, IDX_FAULT, 0);
            chk(q, (t << 3) | f, "fault readback");
            frm.delete();
            for (int i = 0; i < 16; i++) send(i % 8 == 0, 8'h10 + i);
            for (int i = 0; i < 200 && frm.size() < 16 - (t == 3); i++) @(posedge clock);
            chk(frm.size(), 16 - (t == 3), "frame count");
            k = 0;
            for (int i = 0; i < 16; i++) begin
                if (t == 3 && i == f) continue;
                chk(frm[k][8], t == 1 && i == f, "crc fault");
                chk(frm[k][10], i % 8 == 0, "first mark");
                chk(frm[k][9], (t == 2 && i == f) || (t == 3 && i == f + 1), "seq gap");
                if (t == 4 && i == f)
                    chk($onehot(frm[k][7:0] ^ (8'h10 + i)) && !frm[k][0], 1, "rand bit");
                else
                    chk(frm[k][7:0], (8'h10 + i) ^ (t == 5 && i == f), "data");
                k++;
            end
        end
        bus(0, IDX_IRQ_STATUS, 0);
        chk(q[3], 1, "inject status");
        chk_irq(0);
        bus(1, IDX_IRQ_MASK, 32'h08);
        chk_irq(1);
        bus(1, IDX_IRQ_STATUS, 32'h08);
        chk_irq(0);
        $display("test injection done");
        print_verdict();
    end
endmodule
`default_nettype wire
